//--- dv/lsq_far_model.sv
/*
 Far-side model of the sequencer: register file, memory data bus and a
 stand-in arithmetic unit. Assumes the sequencer's clock; the bench sets
 the memory word and the exception request.
*/
`default_nettype none
module lsq_far_model
    import lsq_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic [REG_AW-1:0] rs1_i,
    input wire logic [REG_AW-1:0] rs2_i,
    input wire lsq_rf_wr_type wr_i,
    input wire logic oe_i,
    input wire logic [31:0] drv_i,
    input wire logic [31:0] mem_i,
    input wire logic exc_i,
    input wire logic [31:0] a_i,
    input wire logic [31:0] b_i,
    output logic [31:0] rs1_o,
    output logic [31:0] rs2_o,
    output logic [31:0] rs1_lo_o,
    output logic [31:0] bus_o,
    output logic [31:0] res_o,
    output logic exc_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] rf [32];

    // Each register starts with a pattern carrying its own index
    initial begin
        for (int i = 0; i < 32; i++) begin
            rf[i] = 32'hC000_0000 | 32'(i);
        end
    end

    // Writes commit at the edge, so a read in the same cycle sees old data
    always @(posedge core_clk_i) begin
        if (wr_i.we === 1'b1) begin
            rf[wr_i.addr] <= wr_i.hi;
            if (wr_i.dbl === 1'b1) begin
                rf[wr_i.addr + 5'h01] <= wr_i.lo;
            end
        end
    end

    // Reads are combinational, like the file behind the read ports
    assign rs1_o = rf[rs1_i];
    assign rs2_o = rf[rs2_i];
    assign rs1_lo_o = rf[rs1_i + 5'h01];
    // A released bus shows the memory word, which the bench keeps moving
    assign bus_o = oe_i ? drv_i : mem_i;
    assign res_o = a_i + b_i;
    assign exc_o = exc_i;
endmodule : lsq_far_model
`default_nettype wire

//--- dv/lsq_sequencer_tb_top.sv
/*
 Self-checking bench for the sequencer: a table of load and store kinds,
 then forwarding, trap abort and operate with queue store.
 Assumes the far-side model is compiled before this file.
*/
`default_nettype none
module lsq_sequencer_tb_top
    import lsq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        lsq_kind_type k;
        logic [4:0] r;
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] e0;
        logic [31:0] e1;
    } lsq_row_type;

    localparam lsq_row_type ROWS [6] = '{
        '{LSQ_LD_STATUS, 5'h00, 32'h0000_0C21, 32'hFFFF_FFFF,
          32'h0000_0C21, 32'h0000_0000},
        '{LSQ_ST_STATUS, 5'h00, 32'h0, 32'h0, 32'h0000_0C21, 32'h0},
        '{LSQ_LD_SINGLE, 5'h08, 32'h3F80_0000, 32'h0, 32'h3F80_0000, 32'h0},
        '{LSQ_LD_DOUBLE, 5'h0A, 32'h4000_0000, 32'h1234_5678,
          32'h4000_0000, 32'h1234_5678},
        '{LSQ_ST_SINGLE, 5'h01, 32'h0, 32'h0, 32'hC000_0001, 32'h0},
        '{LSQ_ST_DOUBLE, 5'h02, 32'h0, 32'h0, 32'hC000_0002, 32'hC000_0003}
    };

    logic core_clk_i, srst_i, dec_valid_i, iu_trap_i, exc_req;
    lsq_instr_type dec_i;
    logic [31:0] bus_data_i, op_result_i, mem_word;
    logic [31:0] rf_rs1_data_i, rf_rs2_data_i, rf_rs1_lo_i;
    logic op_except_i, dec_ready_o, fsr_we_o, bus_oe_o;
    logic op_start_o, op_trap_o;
    logic [REG_AW-1:0] rf_rs1_o, rf_rs2_o;
    lsq_rf_wr_type rf_wr_o;
    logic [31:0] fsr_data_o, bus_data_o, op_a_o, op_b_o;
    logic [1:0] queue_count_o;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    int wcnt [32] = '{default: 0};

    lsq_sequencer dut (.core_clk_i, .srst_i, .dec_valid_i, .dec_i,
        .bus_data_i, .iu_trap_i, .op_except_i, .op_result_i,
        .rf_rs1_data_i, .rf_rs2_data_i, .rf_rs1_lo_i, .dec_ready_o,
        .rf_rs1_o, .rf_rs2_o, .rf_wr_o, .fsr_we_o, .fsr_data_o,
        .bus_data_o, .bus_oe_o, .op_a_o, .op_b_o, .op_start_o,
        .op_trap_o, .queue_count_o);

    lsq_far_model far (.core_clk_i, .rs1_i(rf_rs1_o), .rs2_i(rf_rs2_o),
        .wr_i(rf_wr_o), .oe_i(bus_oe_o), .drv_i(bus_data_o),
        .mem_i(mem_word), .exc_i(exc_req), .a_i(op_a_o), .b_i(op_b_o),
        .rs1_o(rf_rs1_data_i), .rs2_o(rf_rs2_data_i),
        .rs1_lo_o(rf_rs1_lo_i), .bus_o(bus_data_i),
        .res_o(op_result_i), .exc_o(op_except_i));

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    // Count register writes per address; aborted loads must leave none
    always @(posedge core_clk_i) begin
        cyc++;
        if (!srst_i && rf_wr_o.we === 1'b1) begin
            wcnt[rf_wr_o.addr]++;
        end
        if (cyc == 3000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict();
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    function automatic lsq_instr_type mk(input lsq_kind_type k,
        input logic [4:0] r, input logic [31:0] iw, input logic [31:0] ia);
        lsq_instr_type t;
        t = '0;
        t.kind = k;
        t.rd = r;
        t.rs1 = r;
        t.rs2 = r + 5'h01;
        t.two_src = (k == LSQ_OPERATE);
        t.calc_cycles = 8'h06;
        t.instr = iw;
        t.addr = ia;
        return t;
    endfunction : mk

    // Offer until taken, then return in the middle of its write stage
    task automatic issue(input lsq_instr_type ins);
        int n;
        @(negedge core_clk_i);
        dec_i = ins;
        dec_valid_i = 1'b1;
        n = 0;
        #1;
        while (dec_ready_o !== 1'b1 && n < 200) begin
            @(negedge core_clk_i);
            #1;
            n++;
        end
        if (n == 200) mismatches++;
        @(negedge core_clk_i);
        dec_valid_i = 1'b0;
    endtask : issue

    initial begin
        int n;
        logic st;
        srst_i = 1'b1;
        dec_valid_i = 1'b0;
        dec_i = '0;
        iu_trap_i = 1'b0;
        exc_req = 1'b0;
        mem_word = 32'h0;
        repeat (2) @(negedge core_clk_i);
        srst_i = 1'b0;
        chk({31'h0, bus_oe_o}, 32'h0);
        chk({30'h0, queue_count_o}, 32'h0);
        // Table: one walk per load and store kind except queue store
        for (int i = 0; i < 6; i++) begin
            issue(mk(ROWS[i].k, ROWS[i].r, 32'h0, 32'h0));
            mem_word = ROWS[i].w0;
            st = ROWS[i].k >= LSQ_ST_SINGLE;
            if (st) begin
                chk({31'h0, bus_oe_o}, 32'h1);
                chk(bus_data_o, ROWS[i].e0);
            end
            @(negedge core_clk_i);
            mem_word = ROWS[i].w1;
            case (ROWS[i].k)
                LSQ_LD_SINGLE: begin
                    chk({31'h0, rf_wr_o.we}, 32'h1);
                    chk({27'h0, rf_wr_o.addr}, {27'h0, ROWS[i].r});
                    chk(rf_wr_o.hi, ROWS[i].e0);
                end
                LSQ_LD_DOUBLE: chk({31'h0, rf_wr_o.we}, 32'h0);
                LSQ_LD_STATUS: chk({31'h0, fsr_we_o}, 32'h1);
                LSQ_ST_DOUBLE: chk(bus_data_o, ROWS[i].e1);
                default: ;
            endcase
            @(negedge core_clk_i);
            mem_word = ~ROWS[i].w1;
            case (ROWS[i].k)
                LSQ_LD_DOUBLE: begin
                    chk({30'h0, rf_wr_o.we, rf_wr_o.dbl}, 32'h3);
                    chk(rf_wr_o.hi, ROWS[i].e0);
                    chk(rf_wr_o.lo, ROWS[i].e1);
                end
                LSQ_LD_STATUS: chk(fsr_data_o, ROWS[i].e0);
                LSQ_ST_DOUBLE: chk({31'h0, bus_oe_o}, 32'h0);
                default: ;
            endcase
        end
        // Load then store of the same register: data must bypass the file
        mem_word = 32'h4049_0FDB;
        issue(mk(LSQ_LD_SINGLE, 5'h03, 32'h0, 32'h0));
        issue(mk(LSQ_ST_SINGLE, 5'h03, 32'h0, 32'h0));
        chk(bus_data_o, 32'h4049_0FDB);
        chk(wcnt[3], 32'h1);
        // Trap during a load: the file must never see its write
        mem_word = 32'h1111_2222;
        issue(mk(LSQ_LD_SINGLE, 5'h05, 32'h0, 32'h0));
        iu_trap_i = 1'b1;
        @(negedge core_clk_i);
        iu_trap_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        chk(wcnt[5], 32'h0);
        // Operate that traps, then the handler drains it by queue store
        exc_req = 1'b1;
        issue(mk(LSQ_OPERATE, 5'h01, 32'h81A0_0A42, 32'h0000_4000));
        n = 0;
        while (op_start_o !== 1'b1 && n < 20) begin
            @(negedge core_clk_i);
            n++;
        end
        chk(op_a_o, 32'hC000_0001);
        chk(op_b_o, 32'hC000_0002);
        n = 0;
        while (op_trap_o !== 1'b1 && n < 40) begin
            @(negedge core_clk_i);
            n++;
        end
        chk({31'h0, op_trap_o}, 32'h1);
        chk(wcnt[1], 32'h0);
        chk({30'h0, queue_count_o}, 32'h1);
        exc_req = 1'b0;
        issue(mk(LSQ_ST_QUEUE, 5'h00, 32'h0, 32'h0));
        chk(bus_data_o, 32'h0000_4000);
        @(negedge core_clk_i);
        chk(bus_data_o, 32'h81A0_0A42);
        @(negedge core_clk_i);
        chk({31'h0, bus_oe_o}, 32'h0);
        @(negedge core_clk_i);
        chk({30'h0, queue_count_o}, 32'h0);
        // Operate without exception writes its result and leaves the queue
        issue(mk(LSQ_OPERATE, 5'h06, 32'h0, 32'h0));
        repeat (9) @(negedge core_clk_i);
        chk(wcnt[6], 32'h1);
        chk({30'h0, queue_count_o}, 32'h0);
        give_verdict();
    end
endmodule : lsq_sequencer_tb_top
`default_nettype wire

//--- rtl/lsq_dep_check.sv
/*
 Dependency checker for the instruction at decode against work in flight.
 Assumes the pending destinations and flags are supplied by the sequencer.
*/
`default_nettype none
module lsq_dep_check
    import lsq_pkg::*;
(
    input wire lsq_instr_type dec_i,
    input wire logic op_busy_i,
    input wire logic [REG_AW-1:0] op_rd_i,
    input wire logic queue_full_i,
    input wire logic wr_load_i,
    input wire logic [REG_AW-1:0] wr_rd_i,
    input wire logic wr_fwd_ok_i,
    input wire logic bus_busy_i,
    output logic stall_o
);
    logic uses_rs1;
    logic uses_rs2;
    logic hit_op;
    logic hit_ld;

    // Sources read by the instruction; loads read none
    always_comb begin
        uses_rs1 = dec_i.kind == LSQ_OPERATE || dec_i.kind == LSQ_ST_SINGLE
            || dec_i.kind == LSQ_ST_DOUBLE;
        uses_rs2 = dec_i.kind == LSQ_OPERATE && dec_i.two_src;
        hit_op = op_busy_i && ((uses_rs1 && dec_i.rs1 == op_rd_i) ||
            (uses_rs2 && dec_i.rs2 == op_rd_i) ||
            (lsq_is_load(dec_i.kind) && dec_i.rd == op_rd_i));
        // A single-word load in its write stages may be forwarded, otherwise wait
        hit_ld = wr_load_i && !wr_fwd_ok_i &&
            ((uses_rs1 && dec_i.rs1 == wr_rd_i) ||
            (uses_rs2 && dec_i.rs2 == wr_rd_i));
        stall_o = dec_i.kind != LSQ_NONE && (hit_op || hit_ld ||
            (dec_i.kind == LSQ_OPERATE && queue_full_i) ||
            (lsq_is_store(dec_i.kind) && bus_busy_i) ||
            (dec_i.kind == LSQ_ST_STATUS && op_busy_i));
    end
endmodule : lsq_dep_check
`default_nettype wire

//--- rtl/lsq_pkg.sv
/*
 Package for the floating-point load/store/operate sequencer: instruction
 classes, stage encodings, carrier structs and timing constants.
 Assumes a single 25 MHz system clock shared with the integer unit.
*/
`default_nettype none
package lsq_pkg;
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned REG_AW = 5;
    localparam int unsigned QUEUE_DEPTH = 2;
    localparam int unsigned OP_CNT_W = 8;
    // Default compute cycles of an operate instruction before its check
    localparam logic [7:0] OP_CALC_DEFAULT = 8'h04;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

    // Instruction classes seen at decode
    typedef enum logic [3:0] {
        LSQ_NONE,
        LSQ_LD_SINGLE,
        LSQ_LD_DOUBLE,
        LSQ_LD_STATUS,
        LSQ_ST_SINGLE,
        LSQ_ST_DOUBLE,
        LSQ_ST_STATUS,
        LSQ_ST_QUEUE,
        LSQ_OPERATE
    } lsq_kind_type;

    // Pipeline stage of the instruction currently past execute
    typedef enum logic [2:0] {
        LSQ_ST_IDLE,
        LSQ_ST_W,
        LSQ_ST_WH1,
        LSQ_ST_WH2
    } lsq_stage_type;

    // Instruction offered by decode
    typedef struct packed {
        lsq_kind_type kind;
        logic [REG_AW-1:0] rd;
        logic [REG_AW-1:0] rs1;
        logic [REG_AW-1:0] rs2;
        logic two_src;
        logic [7:0] calc_cycles;
        logic [31:0] instr;
        logic [31:0] addr;
    } lsq_instr_type;

    // Register file write port
    typedef struct packed {
        logic we;
        logic dbl;
        logic [REG_AW-1:0] addr;
        logic [31:0] hi;
        logic [31:0] lo;
    } lsq_rf_wr_type;

    // Queue entry: instruction word and its address
    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] addr;
    } lsq_qent_type;

    // Load kinds, store kinds decoded once and shared
    function automatic logic lsq_is_load(input lsq_kind_type k);
        return k == LSQ_LD_SINGLE || k == LSQ_LD_DOUBLE ||
            k == LSQ_LD_STATUS;
    endfunction : lsq_is_load

    function automatic logic lsq_is_store(input lsq_kind_type k);
        return k == LSQ_ST_SINGLE || k == LSQ_ST_DOUBLE ||
            k == LSQ_ST_STATUS || k == LSQ_ST_QUEUE;
    endfunction : lsq_is_store
endpackage : lsq_pkg
`default_nettype wire

//--- rtl/lsq_queue.sv
/*
 Two-entry pending queue holding operate instructions and their addresses.
 Assumes push and pop are never requested when full and empty respectively.
*/
`default_nettype none
module lsq_queue
    import lsq_pkg::*;
#(
    parameter int unsigned DEPTH = QUEUE_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic push_i,
    input wire lsq_qent_type push_ent_i,
    input wire logic pop_i,
    input wire logic drop_last_i,
    output lsq_qent_type head_o,
    output logic [1:0] count_o,
    output logic full_o
);
    lsq_qent_type mem_r [DEPTH];
    logic [1:0] count_r;

    // Occupancy; drop removes the newest entry after a trapped load
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            count_r <= 2'h0;
        end else if (drop_last_i && count_r != 2'h0) begin
            count_r <= count_r - 2'h1;
        end else if (push_i && !pop_i) begin
            count_r <= count_r + 2'h1;
        end else if (pop_i && !push_i && count_r != 2'h0) begin
            count_r <= count_r - 2'h1;
        end
    end

    // Shift storage: head is always slot zero
    always_ff @(posedge core_clk_i) begin
        if (pop_i) begin
            mem_r[0] <= (push_i && count_r == 2'h1) ? push_ent_i : mem_r[1];
            mem_r[1] <= push_ent_i;
        end else if (push_i) begin
            mem_r[count_r[0]] <= push_ent_i;
        end
    end

    assign head_o = mem_r[0];
    assign count_o = count_r;
    assign full_o = count_r == 2'(DEPTH);
endmodule : lsq_queue
`default_nettype wire

//--- rtl/lsq_sequencer.sv
/*
 Sequencer for loads, stores and operate instructions of a floating-point
 coprocessor: execute hold, write and write-help stages, forwarding, trap
 abort and queue completion. Assumes the integer unit and the data bus run
 on the same clock; mid-cycle drive is modelled as valid for the cycle.
*/
// How it works
// - Word, status and queue transfers supported
// - Queue store removes one queue entry
// - Load execute stalls on a computing operate's destination
// - Write stage latches word or upper word
// - Stage one writes single/status; latches lower
// - Stage two writes both double words
// - Register write deferred to final stage
// - Later decode overlaps the final load write stage
// - Single-word load data forwarded to next instruction
// - Register write proceeds during forwarding
// - Trap aborts load and drops newest queue entry
// - Store stalls, else reads its source
// - Write stage drives word, upper, address
// - Stage one drives queue word, lower
// - Stage two releases the data bus
// - Store decode overlaps an earlier final write stage
// - Operate execute stalls or reads first
// - Operate write stage reads second, computes
// - Queue compute, check, status, result/trap
// - Operand cycle count varies by operation
// - Queue holds two instruction entries
// - Pipeline freezes on queue dependency
`default_nettype none
module lsq_sequencer
    import lsq_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic dec_valid_i,
    input wire lsq_instr_type dec_i,
    input wire logic [31:0] bus_data_i,
    input wire logic iu_trap_i,
    input wire logic op_except_i,
    input wire logic [31:0] op_result_i,
    input wire logic [31:0] rf_rs1_data_i,
    input wire logic [31:0] rf_rs2_data_i,
    input wire logic [31:0] rf_rs1_lo_i,
    output logic dec_ready_o,
    output logic [REG_AW-1:0] rf_rs1_o,
    output logic [REG_AW-1:0] rf_rs2_o,
    output lsq_rf_wr_type rf_wr_o,
    output logic fsr_we_o,
    output logic [31:0] fsr_data_o,
    output logic [31:0] bus_data_o,
    output logic bus_oe_o,
    output logic [31:0] op_a_o,
    output logic [31:0] op_b_o,
    output logic op_start_o,
    output logic op_trap_o,
    output logic [1:0] queue_count_o
);
    lsq_instr_type ex_r;
    lsq_stage_type stage_r;
    logic [31:0] hi_r;
    logic [31:0] lo_r;
    logic [31:0] st_hi_r;
    logic [31:0] st_lo_r;
    logic [31:0] fsr_r;
    logic busy_r;
    logic [7:0] calc_r;
    logic [REG_AW-1:0] op_rd_r;
    logic op_busy_r;
    logic [REG_AW-1:0] dst_r;
    logic stall;
    logic take;
    logic wr_load;
    logic fwd_ok;
    logic last_stage;
    logic q_push;
    logic q_pop;
    logic q_drop;
    logic q_full;
    lsq_qent_type q_head;
    logic [1:0] q_count;
    logic [31:0] src_hi;
    logic [31:0] src_lo;
    logic [31:0] fwd_word;

    lsq_dep_check u_dep (
        .dec_i(dec_i),
        .op_busy_i(op_busy_r),
        .op_rd_i(op_rd_r),
        .queue_full_i(q_full),
        .wr_load_i(wr_load),
        .wr_rd_i(ex_r.rd),
        .wr_fwd_ok_i(fwd_ok),
        .bus_busy_i(busy_r && !last_stage),
        .stall_o(stall)
    );

    lsq_queue u_queue (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .push_i(q_push),
        .push_ent_i({dec_i.instr, dec_i.addr}),
        .pop_i(q_pop),
        .drop_last_i(q_drop),
        .head_o(q_head),
        .count_o(q_count),
        .full_o(q_full)
    );

    // A load sitting in W or write-help for forwarding and dependency
    assign wr_load = busy_r && lsq_is_load(ex_r.kind);
    // Forwarding only from single-word loads once their word is on the bus
    assign fwd_ok = wr_load && ex_r.kind == LSQ_LD_SINGLE;
    // Decode overlaps only the last write stage; a dependency, a trap or an earlier stage holds
    assign take = dec_valid_i && !stall && !iu_trap_i &&
        (!busy_r || last_stage);
    assign dec_ready_o = !stall && (!busy_r || last_stage);
    assign last_stage = busy_r && (stage_r == LSQ_ST_WH2 ||
        (stage_r == LSQ_ST_WH1 && ex_r.kind != LSQ_LD_DOUBLE &&
        ex_r.kind != LSQ_ST_DOUBLE && ex_r.kind != LSQ_ST_QUEUE) ||
        (stage_r == LSQ_ST_W && (ex_r.kind == LSQ_OPERATE ||
        ex_r.kind == LSQ_ST_SINGLE || ex_r.kind == LSQ_ST_STATUS)));
    assign rf_rs1_o = dec_i.rs1;
    assign rf_rs2_o = ex_r.rs2;
    assign queue_count_o = q_count;

    // Forwarded word when decode reads the register still in flight
    assign fwd_word = (stage_r == LSQ_ST_W) ? bus_data_i : hi_r;
    always_comb begin
        src_hi = rf_rs1_data_i;
        src_lo = rf_rs1_lo_i;
        if (fwd_ok && dec_i.rs1 == ex_r.rd) begin
            src_hi = fwd_word;
        end
    end

    // Instruction in W and write-help stages, one stage per clock
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            busy_r <= 1'b0;
            stage_r <= LSQ_ST_IDLE;
            ex_r <= '0;
        end else if (take) begin
            busy_r <= 1'b1;
            stage_r <= LSQ_ST_W;
            ex_r <= dec_i;
        end else if (iu_trap_i && wr_load) begin
            busy_r <= 1'b0;
            stage_r <= LSQ_ST_IDLE;
        end else if (last_stage) begin
            busy_r <= 1'b0;
            stage_r <= LSQ_ST_IDLE;
        end else if (busy_r) begin
            case (stage_r)
                LSQ_ST_W: stage_r <= LSQ_ST_WH1;
                LSQ_ST_WH1: stage_r <= LSQ_ST_WH2;
                default: stage_r <= LSQ_ST_IDLE;
            endcase
        end
    end

    // Load capture: upper or only word in W, lower word in stage one
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            hi_r <= '0;
            lo_r <= '0;
        end else if (wr_load && stage_r == LSQ_ST_W) begin
            hi_r <= bus_data_i;
        end else if (ex_r.kind == LSQ_LD_DOUBLE && busy_r &&
                stage_r == LSQ_ST_WH1) begin
            lo_r <= bus_data_i;
        end
    end

    // Store source captured at execute from file, status or queue
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_hi_r <= '0;
            st_lo_r <= '0;
        end else if (take) begin
            case (dec_i.kind)
                LSQ_ST_STATUS: st_hi_r <= fsr_r;
                LSQ_ST_QUEUE: begin
                    st_hi_r <= q_head.addr;
                    st_lo_r <= q_head.instr;
                end
                default: begin
                    st_hi_r <= src_hi;
                    st_lo_r <= src_lo;
                end
            endcase
        end
    end

    // Data bus drive: W upper/address, stage one lower/instruction
    always_comb begin
        bus_oe_o = 1'b0;
        bus_data_o = st_hi_r;
        if (busy_r && lsq_is_store(ex_r.kind)) begin
            case (stage_r)
                LSQ_ST_W: bus_oe_o = 1'b1;
                LSQ_ST_WH1: begin
                    bus_oe_o = ex_r.kind == LSQ_ST_DOUBLE ||
                        ex_r.kind == LSQ_ST_QUEUE;
                    bus_data_o = st_lo_r;
                end
                default: bus_oe_o = 1'b0;
            endcase
        end
    end

    // Queue store pops an entry; a trapping operate stays for the handler
    assign q_pop = (busy_r && ex_r.kind == LSQ_ST_QUEUE &&
        stage_r == LSQ_ST_WH2) ||
        (op_busy_r && calc_r == 8'h00 && !op_except_i);
    assign q_push = take && dec_i.kind == LSQ_OPERATE;
    assign q_drop = iu_trap_i && wr_load && op_busy_r;

    // Register file writes: loads at the end of the final write stage, operates at count zero
    always_comb begin
        rf_wr_o = '0;
        rf_wr_o.addr = ex_r.rd;
        rf_wr_o.hi = hi_r;
        rf_wr_o.lo = lo_r;
        if (busy_r && !iu_trap_i) begin
            if (ex_r.kind == LSQ_LD_SINGLE && stage_r == LSQ_ST_WH1) begin
                rf_wr_o.we = 1'b1;
            end
            if (ex_r.kind == LSQ_LD_DOUBLE && stage_r == LSQ_ST_WH2) begin
                rf_wr_o.we = 1'b1;
                rf_wr_o.dbl = 1'b1;
            end
        end
        if (op_busy_r && calc_r == 8'h00 && !op_except_i) begin
            rf_wr_o.we = 1'b1;
            rf_wr_o.dbl = 1'b0;
            rf_wr_o.addr = op_rd_r;
            rf_wr_o.hi = op_result_i;
        end
    end

    // Status register: loaded in stage one, updated on operate completion
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            fsr_r <= STATUS_RESET;
        end else if (busy_r && ex_r.kind == LSQ_LD_STATUS &&
                stage_r == LSQ_ST_WH1 && !iu_trap_i) begin
            fsr_r <= hi_r;
        end else if (op_busy_r && calc_r == 8'h00) begin
            fsr_r[0] <= op_except_i;
        end
    end
    assign fsr_we_o = busy_r && ex_r.kind == LSQ_LD_STATUS &&
        stage_r == LSQ_ST_WH1 && !iu_trap_i;
    assign fsr_data_o = fsr_r;

    // Operate: operands at E and W, then counted compute in the queue
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            op_busy_r <= 1'b0;
            calc_r <= 8'h00;
            op_rd_r <= '0;
            op_a_o <= '0;
            op_b_o <= '0;
            op_start_o <= 1'b0;
            op_trap_o <= 1'b0;
            dst_r <= '0;
        end else begin
            op_start_o <= 1'b0;
            op_trap_o <= 1'b0;
            if (take && dec_i.kind == LSQ_OPERATE) begin
                op_a_o <= src_hi;
                dst_r <= dec_i.rd;
            end
            if (busy_r && ex_r.kind == LSQ_OPERATE && stage_r == LSQ_ST_W) begin
                op_b_o <= ex_r.two_src ? rf_rs2_data_i : 32'h0000_0000;
                op_start_o <= 1'b1;
                op_busy_r <= 1'b1;
                op_rd_r <= dst_r;
                calc_r <= (ex_r.calc_cycles == 8'h00) ?
                    OP_CALC_DEFAULT : ex_r.calc_cycles;
            end else if (q_drop) begin
                op_busy_r <= 1'b0;
            end else if (op_busy_r) begin
                if (calc_r == 8'h00) begin
                    op_busy_r <= 1'b0;
                    op_trap_o <= op_except_i;
                end else begin
                    calc_r <= calc_r - 8'h01;
                end
            end
        end
    end

    // Store kinds never touch the file; loads of status bypass it
    stage_adv_a: assert property (@(posedge core_clk_i)
        disable iff (srst_i) take |=> stage_r == LSQ_ST_W)
        else $error("no W after take");
    dbl_write_a: assert property (@(posedge core_clk_i)
        disable iff (srst_i) rf_wr_o.we && rf_wr_o.dbl |->
        stage_r == LSQ_ST_WH2) else $error("double write off stage two");
    trap_nowr_a: assert property (@(posedge core_clk_i)
        disable iff (srst_i) iu_trap_i && wr_load |->
        !(rf_wr_o.we && !op_busy_r)) else $error("trapped load wrote file");
    bus_rel_a: assert property (@(posedge core_clk_i)
        disable iff (srst_i) stage_r == LSQ_ST_WH2 |-> !bus_oe_o)
        else $error("bus held in stage two");
    st_drive_a: assert property (@(posedge core_clk_i)
        disable iff (srst_i) busy_r && stage_r == LSQ_ST_W &&
        lsq_is_store(ex_r.kind) |-> bus_oe_o)
        else $error("store not driving in W");
    dep_hold_a: assert property (@(posedge core_clk_i)
        disable iff (srst_i) op_busy_r && lsq_is_load(dec_i.kind) &&
        dec_i.rd == op_rd_r |-> !dec_ready_o)
        else $error("load taken over pending write");
    q_bound_a: assert property (@(posedge core_clk_i)
        disable iff (srst_i) q_count <= 2'h2) else $error("queue overfilled");
    ld_cap_a: assert property (@(posedge core_clk_i)
        disable iff (srst_i) wr_load && stage_r == LSQ_ST_W && !take |=>
        hi_r == $past(bus_data_i)) else $error("bus word not latched");
    cv_dbl_c: cover property (@(posedge core_clk_i)
        rf_wr_o.we && rf_wr_o.dbl);
    cv_sq_c: cover property (@(posedge core_clk_i)
        q_pop && ex_r.kind == LSQ_ST_QUEUE);
    cv_trap_c: cover property (@(posedge core_clk_i) op_trap_o);
endmodule : lsq_sequencer
`default_nettype wire
